// [hdl/pbcs_pkg.sv]
// Package with register map, field positions and reset values for the PLL base clock selector
package pbcs_pkg;
   // APB byte addresses
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_BANDWIDTH = 4'h4;
   localparam logic [3:0] ADDR_PROGRAMMING = 4'h8;
   // Control register fields
   localparam int CTL_IRQ_EN_BIT = 7;
   localparam int CTL_FLAG_BIT = 6;
   localparam int CTL_PLL_EN_BIT = 5;
   localparam int CTL_BCS_BIT = 4;
   localparam logic [3:0] CTL_LOW_ONES = 4'hF;
   // Bandwidth register fields
   localparam int BW_AUTO_BIT = 7;
   localparam int BW_LOCK_BIT = 6;
   localparam int BW_TRACK_BIT = 5;
   // Reset values
   localparam logic RST_PLL_EN = 1'b1;
   localparam logic [3:0] RST_MULT = 4'h6;
   localparam logic [3:0] RST_RANGE = 4'h6;
   // Stasis cycles of each source during a switch
   localparam int SWITCH_CYCLES = 3;
   localparam logic [1:0] SWITCH_LAST = 2'h2;
   typedef enum logic [1:0] {PBCS_RUN, PBCS_STALL_OLD, PBCS_STALL_NEW} pbcs_sw_t;
endpackage

// [hdl/pbcs_clk_switch.sv]
// Glitch-free base clock selector with stasis and divide-by-two
`timescale 1ns/1ps
`default_nettype none
module pbcs_clk_switch (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Source enables, one-cycle pulses per source clock edge
   input wire logic xtal_tick,
   input wire logic vco_tick,
   // Selection request
   input wire logic sel_vco,
   // Divided output and status
   output logic base_clock_out,
   output logic busy,
   output logic vco_active
);
   pbcs_pkg::pbcs_sw_t state_reg;
   pbcs_pkg::pbcs_sw_t state_next;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic cur_vco_reg;
   logic cur_vco_next;
   logic out_reg;
   logic out_next;
   wire logic cur_tick = cur_vco_reg ? vco_tick : xtal_tick;
   wire logic new_tick = cur_vco_reg ? xtal_tick : vco_tick;
   wire logic cnt_done = (cnt_reg == pbcs_pkg::SWITCH_LAST);
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cur_vco_next = cur_vco_reg;
      out_next = out_reg;
      unique case (state_reg)
         pbcs_pkg::PBCS_RUN: begin
            if (sel_vco != cur_vco_reg) begin
               state_next = pbcs_pkg::PBCS_STALL_OLD;
               cnt_next = 2'h0;
            end else if (cur_tick) begin
               out_next = ~out_reg;
            end
         end
         // Output frozen: count old source edges, then new ones
         pbcs_pkg::PBCS_STALL_OLD: begin
            if (cur_tick) begin
               cnt_next = cnt_done ? 2'h0 : cnt_reg + 2'h1;
               if (cnt_done) begin
                  state_next = pbcs_pkg::PBCS_STALL_NEW;
               end
            end
         end
         pbcs_pkg::PBCS_STALL_NEW: begin
            if (new_tick) begin
               cnt_next = cnt_done ? 2'h0 : cnt_reg + 2'h1;
               if (cnt_done) begin
                  state_next = pbcs_pkg::PBCS_RUN;
                  cur_vco_next = ~cur_vco_reg;
               end
            end
         end
         default: state_next = pbcs_pkg::PBCS_RUN;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= pbcs_pkg::PBCS_RUN;
         cnt_reg <= 2'h0;
         cur_vco_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cur_vco_reg <= cur_vco_next;
         out_reg <= out_next;
      end
   end
   assign base_clock_out = out_reg;
   assign vco_active = cur_vco_reg;
   assign busy = (state_reg != pbcs_pkg::PBCS_RUN);
endmodule
`default_nettype wire

// [hdl/pbcs_top.sv]
// PLL base clock selector: APB register file, interlocks, lock flag and source switch
// Functional notes
// - A multiplier of zero acts exactly like one.
// - Range zero disables the PLL and forces the crystal source.
// - Source select reads zero, ignores writes, when PLL off or range zero.
// - On select change, output stalls three old and three new source cycles.
// - Base clock is the selected source divided by two.
// - PLL enable stays set and read-only while VCO source selected.
// - One write cannot change PLL enable and source select together.
// - Programming register is read-only while the PLL is enabled.
// - Interrupt enable reads zero, ignores writes, in manual mode; resets zero.
// - Lock-change flag sets on each lock toggle; zero in manual; reset clears.
// - Interrupt asserts when lock-change flag and interrupt enable both set.
// - A control register read clears the lock-change flag; a lock toggle in the same cycle wins.
// - Reset sets PLL enable and clears source select.
// - Low four control bits read as ones.
// - Bandwidth mode bit: one automatic, zero manual; reset clears.
// - Lock reads live lock in automatic mode, zero in manual; reset clears.
// - Track bit: read-only status in auto, keeps manual value; resets zero.
// - Multiplier and range reset to six.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pbcs_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog loop status and source edge enables
   input wire logic pll_locked,
   input wire logic pll_tracking,
   input wire logic crystal_clock,
   input wire logic vco_clock,
   input wire logic osc_enable_in,
   // Loop controls to the analog PLL
   output logic pll_power_on,
   output logic pll_filter_track,
   output logic [3:0] fb_divide,
   output logic [3:0] vco_center_range,
   // Clock and interrupt outputs
   output logic base_clock_out,
   output logic clock_gen_irq
);
   // Effective feedback divide ratio
   function automatic logic [3:0] eff_mult(input logic [3:0] m);
      eff_mult = (m == 4'h0) ? 4'h1 : m;
   endfunction

   logic irq_en_reg;
   logic flag_reg;
   logic pll_en_reg;
   logic bcs_reg;
   logic auto_reg;
   logic track_man_reg;
   logic lock_reg;
   logic [3:0] mult_reg;
   logic [3:0] range_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic pll_on_reg;
   logic track_out_reg;
   logic [3:0] div_reg;
   logic [3:0] vrs_reg;
   logic irq_reg;
   logic base_reg;
   logic xtal_d_reg;
   logic vco_d_reg;

   // Access decode; every transfer gets one wait state, then pready for one cycle
   wire logic access = psel & penable & ~pready_reg;
   wire logic wr = access & pwrite;
   wire logic rd = access & ~pwrite;
   wire logic hit_ctl = (paddr == pbcs_pkg::ADDR_CONTROL);
   wire logic hit_bw = (paddr == pbcs_pkg::ADDR_BANDWIDTH);
   wire logic hit_prg = (paddr == pbcs_pkg::ADDR_PROGRAMMING);
   wire logic unmapped = ~(hit_ctl | hit_bw | hit_prg);
   wire logic wr_ctl = wr & hit_ctl;
   wire logic wr_bw = wr & hit_bw;
   wire logic wr_prg = wr & hit_prg;
   wire logic rd_ctl = rd & hit_ctl;

   wire logic range_zero = (range_reg == 4'h0);
   wire logic w_pll_en = pwdata[pbcs_pkg::CTL_PLL_EN_BIT];
   wire logic w_bcs = pwdata[pbcs_pkg::CTL_BCS_BIT];
   wire logic en_changes = (w_pll_en != pll_en_reg);
   wire logic bcs_changes = (w_bcs != bcs_reg);
   // Both changing in one write is refused for both bits
   wire logic both_change = en_changes & bcs_changes;
   wire logic pll_en_next = (bcs_reg | both_change) ? pll_en_reg : w_pll_en;
   wire logic bcs_allowed = pll_en_reg & ~range_zero & ~both_change;
   wire logic bcs_next = bcs_allowed ? w_bcs : bcs_reg;
   wire logic lock_toggle = auto_reg & (pll_locked != lock_reg);
   wire logic track_view = auto_reg ? pll_tracking : track_man_reg;

   wire logic [7:0] ctl_view = {irq_en_reg & auto_reg, flag_reg & auto_reg, pll_en_reg, bcs_reg,
                                pbcs_pkg::CTL_LOW_ONES};
   wire logic [7:0] bw_view = {auto_reg, lock_reg & auto_reg, track_view, 5'h00};
   wire logic [7:0] prg_view = {mult_reg, range_reg};
   wire logic [7:0] rd_view = hit_ctl ? ctl_view : (hit_bw ? bw_view : (hit_prg ? prg_view : 8'h00));

   // Source selection with the range-zero override
   wire logic sel_vco = bcs_reg & pll_en_reg & ~range_zero;
   wire logic sw_base;
   wire logic sw_busy;
   wire logic sw_vco;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_en_reg <= pbcs_pkg::RST_PLL_EN;
         bcs_reg <= 1'b0;
      end else begin
         // Range zero only pins the select; the enable bit stays writable
         if (wr_ctl) begin
            pll_en_reg <= pll_en_next;
         end
         if (range_zero) begin
            bcs_reg <= 1'b0;
         end else if (wr_ctl) begin
            bcs_reg <= bcs_next;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_reg <= 1'b0;
      end else if (!auto_reg) begin
         irq_en_reg <= 1'b0;
      end else if (wr_ctl) begin
         irq_en_reg <= pwdata[pbcs_pkg::CTL_IRQ_EN_BIT];
      end
   end

   // Toggle wins over the read clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
      end else if (lock_toggle) begin
         flag_reg <= 1'b1;
      end else if (rd_ctl || !auto_reg) begin
         flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_reg <= 1'b0;
         track_man_reg <= 1'b0;
      end else if (wr_bw) begin
         auto_reg <= pwdata[pbcs_pkg::BW_AUTO_BIT];
         if (!auto_reg) begin
            track_man_reg <= pwdata[pbcs_pkg::BW_TRACK_BIT];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_reg <= 1'b0;
      end else begin
         lock_reg <= auto_reg & pll_locked;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mult_reg <= pbcs_pkg::RST_MULT;
         range_reg <= pbcs_pkg::RST_RANGE;
      end else if (wr_prg && !pll_en_reg) begin
         mult_reg <= pwdata[7:4];
         range_reg <= pwdata[3:0];
      end
   end

   // APB answer registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= access;
         pslverr_reg <= access & unmapped;
         if (rd) begin
            prdata_reg <= {24'h00_0000, rd_view};
         end
      end
   end

   // Edge enables of the source clocks, sampled as synchronous inputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xtal_d_reg <= 1'b0;
         vco_d_reg <= 1'b0;
      end else begin
         xtal_d_reg <= crystal_clock;
         vco_d_reg <= vco_clock & pll_on_reg;
      end
   end
   wire logic xtal_tick = crystal_clock & ~xtal_d_reg & osc_enable_in;
   wire logic vco_tick = vco_clock & pll_on_reg & ~vco_d_reg;

   pbcs_clk_switch u_switch (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .xtal_tick(xtal_tick),
      .vco_tick(vco_tick),
      .sel_vco(sel_vco),
      .base_clock_out(sw_base),
      .busy(sw_busy),
      .vco_active(sw_vco)
   );

   // Output registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_on_reg <= 1'b0;
         track_out_reg <= 1'b0;
         div_reg <= 4'h1;
         vrs_reg <= 4'h0;
         irq_reg <= 1'b0;
         base_reg <= 1'b0;
      end else begin
         // Loop stays powered until the switch has really left the VCO
         pll_on_reg <= (pll_en_reg & ~range_zero & osc_enable_in) | sw_vco | (sw_busy & ~sel_vco);
         track_out_reg <= track_view;
         div_reg <= eff_mult(mult_reg);
         vrs_reg <= range_reg;
         irq_reg <= flag_reg & irq_en_reg & auto_reg;
         base_reg <= sw_base;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pll_power_on = pll_on_reg;
   assign pll_filter_track = track_out_reg;
   assign fb_divide = div_reg;
   assign vco_center_range = vrs_reg;
   assign clock_gen_irq = irq_reg;
   assign base_clock_out = base_reg;
endmodule
`default_nettype wire

// [verif/pbcs_checker.sv]
// Port assertions for the PLL base clock selector
`timescale 1ns/1ps
`default_nettype none
module pbcs_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Loop and clock
   input wire logic pll_locked,
   input wire logic [3:0] fb_divide,
   input wire logic [3:0] vco_center_range,
   input wire logic base_clock_out,
   input wire logic clock_gen_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire rd = psel && penable && pready && !pwrite && !pslverr;
   wire rd_c = rd && paddr == pbcs_pkg::ADDR_CONTROL;
   wire rd_b = rd && paddr == pbcs_pkg::ADDR_BANDWIDTH;
   wire rd_p = rd && paddr == pbcs_pkg::ADDR_PROGRAMMING;
   sequence s_edge; $changed(base_clock_out); endsequence
   sequence s_hold; $stable(base_clock_out)[*3]; endsequence
   a_low_ones: assert property (rd_c |-> prdata[3:0] == 4'hF) else $error("low bits");
   a_vco_needs_on: assert property (rd_c && prdata[4] |-> prdata[5]) else $error("select without pll");
   a_range_zero_sel: assert property (rd_c && vco_center_range == 4'h0 |-> !prdata[4]) else $error("range0");
   a_lock_manual: assert property (rd_b && !prdata[7] |-> !prdata[6]) else $error("lock in manual");
   a_div_map: assert property (rd_p |-> fb_divide == (prdata[7:4] == 4'h0 ? 4'h1 : prdata[7:4]))
      else $error("divider");
   a_irq_needs_en: assert property (rd_c && !prdata[7] |-> !clock_gen_irq) else $error("irq");
   a_irq_read_clr: assert property (rd_c && $stable(pll_locked) |=> !clock_gen_irq) else $error("flag clr");
   // Sources run slower than a quarter of the core rate in the bench
   a_base_div: assert property (s_edge |=> s_hold) else $error("base edge");
endmodule
`default_nettype wire

// [verif/pbcs_far_model.sv]
// Crystal, VCO and analog loop beside the selector
`timescale 1ns/1ps
`default_nettype none
module pbcs_far_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Loop control
   input wire logic pll_power_on,
   input wire logic lock_req,
   // Sources and status
   output logic crystal_clock,
   output logic vco_clock,
   output logic pll_locked,
   output logic pll_tracking
);
   logic [2:0] xc;
   logic [3:0] vc;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xc <= 3'h0;
         vc <= 4'h0;
      end else begin
         xc <= xc + 3'h1;
         vc <= (vc == 4'h9) ? 4'h0 : vc + 4'h1;
      end
   end
   assign crystal_clock = xc[2];
   // An unpowered VCO gives no edges, so a wrong switch shows as a dead output
   assign vco_clock = pll_power_on && vc > 4'h4;
   assign pll_locked = pll_power_on && lock_req;
   assign pll_tracking = pll_locked;
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the PLL base clock selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [3:0] C = pbcs_pkg::ADDR_CONTROL;
   localparam logic [3:0] B = pbcs_pkg::ADDR_BANDWIDTH;
   localparam logic [3:0] P = pbcs_pkg::ADDR_PROGRAMMING;
   logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lock_req = 1'b0;
   logic osc_en = 1'b1;
   logic [3:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pll_locked, pll_tracking, crystal_clock, vco_clock, err;
   logic pll_power_on, pll_filter_track, base_clock_out, clock_gen_irq;
   logic [3:0] fb_divide, vco_center_range;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   always #2.5 core_clk = ~core_clk;
   pbcs_top u_pbcs_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pll_locked(pll_locked), .pll_tracking(pll_tracking), .crystal_clock(crystal_clock),
      .vco_clock(vco_clock), .osc_enable_in(osc_en), .pll_power_on(pll_power_on),
      .pll_filter_track(pll_filter_track), .fb_divide(fb_divide), .vco_center_range(vco_center_range),
      .base_clock_out(base_clock_out), .clock_gen_irq(clock_gen_irq));
   pbcs_far_model u_pbcs_far_model (.core_clk(core_clk), .rst_n(rst_n), .pll_power_on(pll_power_on),
      .lock_req(lock_req), .crystal_clock(crystal_clock), .vco_clock(vco_clock), .pll_locked(pll_locked),
      .pll_tracking(pll_tracking));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Waiting an edge first keeps back-to-back calls from driving psel twice in one step
   task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check(rd, {24'h0, e});
   endtask
   task automatic t_count(input int n, input int e);
      int k = 0;
      logic last;
      last = base_clock_out;
      repeat (n) begin
         @(posedge core_clk);
         if (base_clock_out !== last) k++;
         last = base_clock_out;
      end
      check(k, e);
   endtask
   task automatic t_reset;
      rdc(C, 8'h2F);
      rdc(B, 8'h00);
      rdc(P, 8'h66);
      check(fb_divide, 4'h6);
      check(vco_center_range, 4'h6);
      apb(1'b0, 4'hC, 8'h00);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
   endtask
   task automatic t_prog;
      wr(P, 8'h35);
      rdc(P, 8'h66);
      wr(C, 8'h00);
      wr(P, 8'h05);
      rdc(P, 8'h05);
      check(fb_divide, 4'h1);
   endtask
   task automatic t_switch;
      wr(C, 8'h30);
      rdc(C, 8'h0F);
      t_count(400, 50);
      wr(C, 8'h20);
      wr(C, 8'h30);
      rdc(C, 8'h3F);
      repeat (100) @(posedge core_clk);
      t_count(400, 40);
      wr(C, 8'h00);
      rdc(C, 8'h3F);
      wr(C, 8'h10);
      rdc(C, 8'h3F);
      wr(C, 8'h20);
      rdc(C, 8'h2F);
   endtask
   task automatic t_range0;
      wr(C, 8'h00);
      wr(P, 8'h50);
      wr(C, 8'h20);
      wr(C, 8'h30);
      rdc(C, 8'h2F);
      // The switch back to the crystal keeps the loop powered until it ends
      repeat (100) @(posedge core_clk);
      check(pll_power_on, 1'b0);
      wr(C, 8'h00);
      wr(P, 8'h66);
   endtask
   task automatic t_auto;
      wr(C, 8'h80);
      rdc(C, 8'h0F);
      wr(B, 8'h20);
      rdc(B, 8'h20);
      // Track bit kept at one so the manual value survives the mode change
      wr(B, 8'hA0);
      wr(C, 8'h20);
      wr(C, 8'hA0);
      lock_req <= 1'b1;
      repeat (10) @(posedge core_clk);
      check(clock_gen_irq, 1'b1);
      rdc(B, 8'hE0);
      check(pll_filter_track, 1'b1);
      rdc(C, 8'hEF);
      rdc(C, 8'hAF);
      check(clock_gen_irq, 1'b0);
      wr(B, 8'h00);
      rdc(B, 8'h20);
      rdc(C, 8'h2F);
      // A stopped oscillator gives the divider no edges to follow
      osc_en <= 1'b0;
      repeat (4) @(posedge core_clk);
      t_count(40, 0);
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_prog();
      t_switch();
      t_range0();
      t_auto();
      give_verdict();
   end
endmodule
bind pbcs_top pbcs_checker u_pbcs_checker (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pll_locked(pll_locked), .fb_divide(fb_divide), .vco_center_range(vco_center_range),
   .base_clock_out(base_clock_out), .clock_gen_irq(clock_gen_irq));
`default_nettype wire
